/* File: verilog/fidp_regs.vh */
// Purpose: Constants for the flash identity and power-down command block.
// Assumes: Included by the design file of this block and by the bench.
// Notes:   Times are in nanoseconds; cycle counts derive from a 4 ns clock.
`ifndef FIDP_REGS_VH
`define FIDP_REGS_VH

`define FIDP_CLK_NS          4
`define FIDP_OP_PWR_DOWN     8'hB9
`define FIDP_OP_RELEASE_ID   8'hAB
`define FIDP_OP_MFR_DEV_ID   8'h90
`define FIDP_OP_MFR_DEV_DUAL 8'h92
`define FIDP_OP_MFR_DEV_QUAD 8'h94
`define FIDP_OP_UNIQUE_ID    8'h4B
`define FIDP_OP_IDENTITY     8'h9F
`define FIDP_OP_RESET_EN     8'h66
`define FIDP_OP_RESET        8'h99
`define FIDP_PD_ENTRY_NS     3000
`define FIDP_RELEASE_NS      3000
`define FIDP_RELEASE_ID_NS   3000
`define FIDP_PD_ENTRY_CYC    ((`FIDP_PD_ENTRY_NS) / `FIDP_CLK_NS)
`define FIDP_RELEASE_CYC     ((`FIDP_RELEASE_NS + `FIDP_CLK_NS - 1) / `FIDP_CLK_NS)
`define FIDP_RELEASE_ID_CYC  ((`FIDP_RELEASE_ID_NS + `FIDP_CLK_NS - 1) / `FIDP_CLK_NS)
`define FIDP_RELEASE_ID_DUMMY 24
`define FIDP_UNIQUE_DUMMY    32
`define FIDP_ADDR_BITS       24
`define FIDP_MODE_BITS       8
`define FIDP_QUAD_DUMMY_CLK  4

`endif

/* File: verilog/fidp_sync.v */
// Purpose: Two flip-flop synchroniser for a bus of pin inputs.
// Assumes: Inputs come from outside the clk_i domain.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module fidp_sync #(
  parameter W = 6
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  input  wire [W-1:0] rst_val_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  // The reset value comes from a constant at the instance.
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= rst_val_i;
      q_o    <= rst_val_i;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // fidp_sync

`default_nettype wire

/* File: verilog/fidp_flash_id.v */
// Purpose: Power-down entry and release and the identity reads of a serial flash.
// Assumes: Serial clock, chip select and data pins are oversampled by clk_i.
// Notes:   Input is sampled on rising serial clock edges, output changes on falling.
`default_nettype none
`include "fidp_regs.vh"

// Behaviour
// - Enter power-down within entry time after deselect
// - Power-down only if deselected after eighth bit
// - Power-down accepts only release and resets
// - Start in normal mode after reset
// - Release alone resumes after release time
// - Release/ID with three dummies streams device ID
// - Release with ID waits release-with-ID time
// - Release/ID ignored while busy
// - Single ID read returns maker then device
// - Address one swaps order; bytes alternate continuously
// - Dual ID read: two bits per clock
// - Quad ID read: four bits, four dummy clocks
// - Unique read: four dummy bytes, 128 bits
// - Unique number fixed, read-only
// - Identity read: maker, type, capacity
// - Dual, quad, unique only in serial mode
// - Power, release/ID, single maker/device and identity opcodes in both modes
module fidp_flash_id #(
  parameter [7:0]   MFR_ID     = 8'h5A,  // Arbitrary value.
  parameter [7:0]   DEV_ID     = 8'h16,  // Arbitrary value.
  parameter [7:0]   MEM_TYPE   = 8'h40,  // Arbitrary value.
  parameter [7:0]   CAPACITY   = 8'h17,  // Arbitrary value.
  parameter [127:0] UNIQUE_ID  = 128'h0123456789ABCDEFFEDCBA9876543210,  // Arbitrary value.
  parameter integer PD_CYC     = `FIDP_PD_ENTRY_CYC,
  parameter integer REL_CYC    = `FIDP_RELEASE_CYC,
  parameter integer REL_ID_CYC = `FIDP_RELEASE_ID_CYC
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       cs_n_i,
  input  wire       sclk_i,
  input  wire [3:0] io_i,
  output reg  [3:0] io_o,
  output reg  [3:0] io_oe_n_o,
  input  wire       quad_mode_i,
  input  wire       busy_i,
  input  wire       hw_reset_n_i,
  output wire       powered_down_o,
  output wire       ready_o,
  output wire       soft_reset_o
);
  localparam [2:0] ST_OPCODE = 3'd0;
  localparam [2:0] ST_ADDR   = 3'd1;
  localparam [2:0] ST_DUMMY  = 3'd2;
  localparam [2:0] ST_OUT    = 3'd3;
  localparam [2:0] ST_IGNORE = 3'd4;

  localparam [1:0] PW_NORMAL = 2'd0;
  localparam [1:0] PW_ENTER  = 2'd1;
  localparam [1:0] PW_DOWN   = 2'd2;
  localparam [1:0] PW_WAKE   = 2'd3;

  localparam [2:0] RD_NONE = 3'd0;
  localparam [2:0] RD_DEV  = 3'd1;
  localparam [2:0] RD_MFR  = 3'd2;
  localparam [2:0] RD_UNQ  = 3'd3;
  localparam [2:0] RD_JED  = 3'd4;

  wire [5:0] pins_s;
  fidp_sync #(
    .W (6)
  ) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       ({cs_n_i, sclk_i, io_i}),
    .rst_val_i (6'h30),
    .q_o       (pins_s)
  );

  wire       cs_n_s = pins_s[5];
  wire       sclk_s = pins_s[4];
  wire [3:0] io_s   = pins_s[3:0];

  reg         sclk_q;
  reg         cs_n_q;
  reg  [2:0]  st_q;
  reg  [1:0]  pw_q;
  reg  [2:0]  rd_q;
  reg  [2:0]  width_q;
  reg  [7:0]  opc_q;
  reg  [7:0]  cnt_q;
  reg  [23:0] addr_q;
  reg  [6:0]  bit_q;
  reg         swap_q;
  reg         rel_id_q;
  reg         rst_en_q;
  reg         soft_rst_q;
  reg  [15:0] tmr_q;

  // Edges are found on the synchronised copies, so every action trails the pin by about
  // three clocks; the serial clock must stay well below a sixth of clk_i for that reason.
  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire cs_rise   = cs_n_s & ~cs_n_q;
  wire in_pd     = (pw_q == PW_DOWN);

  // Bits entered per serial clock in the opcode phase.
  wire [2:0] cmd_w = quad_mode_i ? 3'd4 : 3'd1;
  wire [7:0] opc_shift = (cmd_w == 3'd4) ? {opc_q[3:0], io_s} : {opc_q[6:0], io_s[0]};
  wire [7:0] opc_bits  = cnt_q + {5'h00, cmd_w};

  // Byte of the stream that currently sits on the output lines.
  reg [7:0] out_byte;
  always @* begin
    out_byte = 8'h00;
    case (rd_q)
      RD_DEV: out_byte = DEV_ID;
      RD_MFR: out_byte = (bit_q[3] ^ swap_q) ? DEV_ID : MFR_ID;
      RD_JED: out_byte = (bit_q[4:3] == 2'd0) ? MFR_ID :
                         (bit_q[4:3] == 2'd1) ? MEM_TYPE : CAPACITY;
      default: out_byte = 8'h00;
    endcase
  end

  // The unique number is a parameter, so no command path can write it.
  wire [127:0] unq_rot = UNIQUE_ID << bit_q;
  wire [7:0]   cur_byte = (rd_q == RD_UNQ) ? unq_rot[127:120] : (out_byte << bit_q[2:0]);

  // Command decode at the eighth opcode bit; decode honours the mode restrictions.
  reg [2:0] nxt_st;
  reg [2:0] nxt_rd;
  reg [2:0] nxt_w;
  reg [7:0] nxt_cnt;
  always @* begin
    nxt_st  = ST_IGNORE;
    nxt_rd  = RD_NONE;
    nxt_w   = cmd_w;
    nxt_cnt = 8'h00;
    if (in_pd) begin
      if (opc_shift == `FIDP_OP_RELEASE_ID && !busy_i) begin
        nxt_st  = ST_DUMMY;
        nxt_rd  = RD_DEV;
        nxt_cnt = 8'd`FIDP_RELEASE_ID_DUMMY;
      end
    end else begin
      case (opc_shift)
        `FIDP_OP_RELEASE_ID: if (!busy_i) begin
          nxt_st  = ST_DUMMY;
          nxt_rd  = RD_DEV;
          nxt_cnt = 8'd`FIDP_RELEASE_ID_DUMMY;
        end
        `FIDP_OP_MFR_DEV_ID: begin
          nxt_st  = ST_ADDR;
          nxt_rd  = RD_MFR;
          nxt_cnt = 8'd`FIDP_ADDR_BITS;
        end
        `FIDP_OP_MFR_DEV_DUAL: if (!quad_mode_i) begin
          nxt_st  = ST_ADDR;
          nxt_rd  = RD_MFR;
          nxt_w   = 3'd2;
          nxt_cnt = 8'd`FIDP_ADDR_BITS + 8'd`FIDP_MODE_BITS;
        end
        `FIDP_OP_MFR_DEV_QUAD: if (!quad_mode_i) begin
          nxt_st  = ST_ADDR;
          nxt_rd  = RD_MFR;
          nxt_w   = 3'd4;
          nxt_cnt = 8'd`FIDP_ADDR_BITS + 8'd`FIDP_MODE_BITS + 8'd16;
        end
        `FIDP_OP_UNIQUE_ID: if (!quad_mode_i) begin
          nxt_st  = ST_DUMMY;
          nxt_rd  = RD_UNQ;
          nxt_cnt = 8'd`FIDP_UNIQUE_DUMMY;
        end
        `FIDP_OP_IDENTITY: begin
          nxt_st  = ST_OUT;
          nxt_rd  = RD_JED;
        end
        default: nxt_st = ST_IGNORE;
      endcase
    end
  end

  // Input bits per serial clock in the address and dummy phases follow width_q from the decode.
  wire [7:0] in_step = {5'h00, width_q};

  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q     <= 1'b0;
      cs_n_q     <= 1'b1;
      st_q       <= ST_OPCODE;
      pw_q       <= PW_NORMAL;
      rd_q       <= RD_NONE;
      width_q    <= 3'd1;
      opc_q      <= 8'h00;
      cnt_q      <= 8'h00;
      addr_q     <= 24'h000000;
      bit_q      <= 7'h00;
      swap_q     <= 1'b0;
      rel_id_q   <= 1'b0;
      rst_en_q   <= 1'b0;
      soft_rst_q <= 1'b0;
      tmr_q      <= 16'h0000;
      io_o       <= 4'h0;
      io_oe_n_o  <= 4'hF;
    end else begin
      sclk_q     <= sclk_s;
      cs_n_q     <= cs_n_s;
      soft_rst_q <= 1'b0;
      if (!hw_reset_n_i) begin
        // A hardware reset leaves power-down at once and aborts any frame.
        pw_q      <= PW_NORMAL;
        // A frame still selected stays ignored; an idle bus is ready for the next opcode.
        st_q      <= cs_n_s ? ST_OPCODE : ST_IGNORE;
        cnt_q     <= 8'h00;
        opc_q     <= 8'h00;
        tmr_q     <= 16'h0000;
        rst_en_q  <= 1'b0;
        io_oe_n_o <= 4'hF;
      end else if (cs_n_s) begin
        io_oe_n_o <= 4'hF;
        if (cs_rise) begin
          st_q  <= ST_OPCODE;
          cnt_q <= 8'h00;
          opc_q <= 8'h00;
          // Power-down is taken only when the frame ended right after the opcode.
          if (pw_q == PW_NORMAL && st_q == ST_IGNORE && opc_q == `FIDP_OP_PWR_DOWN
              && cnt_q == 8'd8) begin
            pw_q  <= PW_ENTER;
            tmr_q <= PD_CYC[15:0];
          end else if (in_pd && st_q == ST_DUMMY && rd_q == RD_DEV) begin
            // Release alone: the frame ended before the dummy bytes were done, so no identifier streamed.
            pw_q  <= PW_WAKE;
            tmr_q <= (rel_id_q ? REL_ID_CYC[15:0] : REL_CYC[15:0]);
          end else if (in_pd && st_q == ST_OUT && rd_q == RD_DEV) begin
            pw_q  <= PW_WAKE;
            tmr_q <= REL_ID_CYC[15:0];
          end
          if (st_q == ST_IGNORE && opc_q == `FIDP_OP_RESET_EN && cnt_q == 8'd8)
            rst_en_q <= 1'b1;
          else if (st_q == ST_IGNORE && opc_q == `FIDP_OP_RESET && cnt_q == 8'd8
                   && rst_en_q) begin
            rst_en_q   <= 1'b0;
            soft_rst_q <= 1'b1;
            pw_q       <= PW_NORMAL;
          end else
            rst_en_q <= 1'b0;
          rel_id_q <= 1'b0;
        end else if (tmr_q != 16'h0000) begin
          tmr_q <= tmr_q - 16'h0001;
        end else if (pw_q == PW_ENTER) begin
          pw_q <= PW_DOWN;
        end else if (pw_q == PW_WAKE) begin
          pw_q <= PW_NORMAL;
        end
      end else if (pw_q == PW_NORMAL || pw_q == PW_DOWN) begin
        if (sclk_rise) begin
          case (st_q)
            ST_OPCODE: begin
              opc_q <= opc_shift;
              cnt_q <= opc_bits;
              if (opc_bits == 8'd8) begin
                // Counting on past the eighth bit exposes a late deselect.
                st_q    <= nxt_st;
                rd_q    <= nxt_rd;
                width_q <= nxt_w;
                swap_q  <= 1'b0;
                bit_q   <= 7'h00;
                addr_q  <= 24'h000000;
                if (nxt_st != ST_IGNORE)
                  cnt_q <= nxt_cnt;
              end
            end
            ST_ADDR: begin
              if (width_q == 3'd4)
                addr_q <= {addr_q[19:0], io_s};
              else if (width_q == 3'd2)
                addr_q <= {addr_q[21:0], io_s[1:0]};
              else
                addr_q <= {addr_q[22:0], io_s[0]};
              // Address bits are followed by mode bits and dummies in one count.
              // For the quad ID read the address is complete once only mode bits and
              // dummy clocks remain, so its low bit is picked up from the shifter there.
              if (cnt_q == 8'd`FIDP_MODE_BITS + 8'd16 && width_q == 3'd4
                  && opc_q == `FIDP_OP_MFR_DEV_QUAD)
                swap_q <= addr_q[0];
              if (cnt_q <= in_step) begin
                st_q <= ST_OUT;
                // Plain ID reads end on the address, so the last lane sampled holds its low bit.
                if (width_q == 3'd1)
                  swap_q <= io_s[0];
                else if (width_q == 3'd4 && opc_q == `FIDP_OP_MFR_DEV_ID)
                  swap_q <= io_s[0];
                else if (width_q == 3'd2 && cnt_q > 8'd`FIDP_MODE_BITS)
                  swap_q <= io_s[0];
              end else begin
                cnt_q <= cnt_q - in_step;
                if (width_q == 3'd2 && cnt_q == 8'd`FIDP_MODE_BITS + 8'd2)
                  swap_q <= io_s[0];
              end
            end
            ST_DUMMY: begin
              if (cnt_q <= in_step) begin
                st_q     <= ST_OUT;
                rel_id_q <= in_pd;
              end else
                cnt_q <= cnt_q - in_step;
            end
            ST_OUT, ST_IGNORE: cnt_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
            default: st_q <= ST_IGNORE;
          endcase
        end
        if (sclk_fall && st_q == ST_OUT) begin
          io_oe_n_o <= (width_q == 3'd4) ? 4'h0 : (width_q == 3'd2) ? 4'hC : 4'hD;
          if (width_q == 3'd4)
            io_o <= cur_byte[7:4];
          else if (width_q == 3'd2)
            io_o <= {2'b00, cur_byte[7:6]};
          else
            io_o <= {2'b00, cur_byte[7], 1'b0};
          // Identity bytes wrap so output repeats until deselect.
          if (rd_q == RD_JED && bit_q + {4'h0, width_q} >= 7'd24)
            bit_q <= 7'h00;
          else if (rd_q == RD_DEV && bit_q + {4'h0, width_q} >= 7'd8)
            bit_q <= 7'h00;
          else if (rd_q == RD_MFR && bit_q + {4'h0, width_q} >= 7'd16)
            bit_q <= 7'h00;
          else
            bit_q <= bit_q + {4'h0, width_q};
        end
      end
    end
  end

  assign powered_down_o = in_pd;
  assign ready_o        = (pw_q == PW_NORMAL) || (pw_q == PW_DOWN);
  assign soft_reset_o   = soft_rst_q;
endmodule // fidp_flash_id

`default_nettype wire

/* File: bench/fidp_props.sv */
// Purpose: Port-level assertions for the flash identity and power-down block.
// Assumes: One clock domain with a synchronous, active-high reset.
// Notes:   Timer bounds scale with PD_CYC, so short simulation timers stay covered.
`default_nettype none
module fidp_props #(
  parameter integer PD_CYC = 10
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cs_n_i,
  input wire logic       sclk_i,
  input wire logic       quad_mode_i,
  input wire logic       busy_i,
  input wire logic       hw_reset_n_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_n_o,
  input wire logic       powered_down_o,
  input wire logic       ready_o,
  input wire logic       soft_reset_o
);
  localparam int LIM = 3 * PD_CYC + 10;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_vals: assert property (
    $fell(rst_i) |-> io_oe_n_o == 4'hF && !powered_down_o && ready_o)
    else $error("outputs not idle after reset");
  a_cs_release: assert property (cs_n_i [*5] |-> io_oe_n_o == 4'hF)
    else $error("data pins driven while deselected");
  a_oe_codes: assert property (io_oe_n_o inside {4'hF, 4'hD, 4'hC, 4'h0})
    else $error("illegal lane enable pattern");
  a_quad_lanes: assert property (
    quad_mode_i && io_oe_n_o != 4'hF |-> io_oe_n_o == 4'h0)
    else $error("quad command mode output not on four lanes");
  a_out_on_fall: assert property (
    $changed(io_o) && io_oe_n_o != 4'hF |->
    !$past(sclk_i, 2) || !$past(sclk_i, 3) || !$past(sclk_i, 4))
    else $error("output changed away from a falling serial clock");
  a_timer_span: assert property ($fell(ready_o) |-> ##[1:LIM] ready_o)
    else $error("entry or release timer too long");
  a_pd_after_cs: assert property (
    $rose(powered_down_o) |-> cs_n_i && $past(cs_n_i, 4))
    else $error("power-down entered while selected");
  a_soft_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset longer than one cycle");
  a_soft_wake: assert property (soft_reset_o |-> ##[0:3] !powered_down_o)
    else $error("soft reset did not leave power-down");
  a_hw_wake: assert property (!hw_reset_n_i |-> ##[0:4] !powered_down_o)
    else $error("hardware reset did not leave power-down");
  a_busy_hold: assert property (
    busy_i && powered_down_o && hw_reset_n_i && !soft_reset_o |=> powered_down_o)
    else $error("power-down left while busy");
endmodule // fidp_props
bind fidp_flash_id fidp_props #(.PD_CYC(PD_CYC)) fidp_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .quad_mode_i(quad_mode_i), .busy_i(busy_i), .hw_reset_n_i(hw_reset_n_i),
  .io_o(io_o), .io_oe_n_o(io_oe_n_o), .powered_down_o(powered_down_o),
  .ready_o(ready_o), .soft_reset_o(soft_reset_o));
`default_nettype wire

/* File: bench/fidp_host.sv */
// Purpose: Behavioural host serial controller that drives the flash pins.
// Assumes: Serial clock idles low and toggles only inside frames.
// Notes:   A released lane shows the inverse of its last value, never a held copy.
`default_nettype none
module fidp_host (
  input  wire logic       clk_i,
  input  wire logic [3:0] io_i,
  output var  logic       cs_n_o,
  output var  logic       sclk_o,
  output wire logic [3:0] io_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] v;
  logic       en;
  assign io_o = en ? v : ~v;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    v = 4'h0;
    en = 1'b0;
  end
  // Each clock moves l lanes; sampling just before the fall gives the device time.
  task automatic sh(input logic [127:0] d, input int n, input int l, input bit rx,
                    inout logic [127:0] r);
    repeat (n / l) begin
      en = !rx;
      if (!rx) v = 4'(d[127:124] >> (4 - l));
      d = d << l;
      #16 sclk_o = 1'b1;
      #15 r = (r << l) | 128'((l == 1) ? io_i[1] : io_i & 4'((1 << l) - 1));
      #1 sclk_o = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] op, input int ol, input logic [127:0] pre,
                       input int np, input int pl, input int nr, input int rl,
                       output logic [127:0] r);
    r = '0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    #16;
    sh({op, 120'h0}, 8, ol, 1'b0, r);
    sh(pre, np, pl, 1'b0, r);
    r = '0;
    sh('0, nr, rl, 1'b1, r);
    en = 1'b0;
    #16 cs_n_o = 1'b1;
    #40;
  endtask
endmodule // fidp_host
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the flash identity and power-down block.
// Assumes: Timers shortened to 10 cycles; the host model drives the serial pins.
// Notes:   Identity values are arbitrary bench choices, passed in as parameters.
`default_nettype none
`include "fidp_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]   M = 8'h3C; // Arbitrary value.
  localparam logic [7:0]   D = 8'h21; // Arbitrary value.
  localparam logic [7:0]   T = 8'h45; // Arbitrary value.
  localparam logic [7:0]   C = 8'h18; // Arbitrary value.
  localparam logic [127:0] U = 128'h93E15A07C24B66F01D38A9B274C50E8F; // Arbitrary value.
  logic         clk_i, rst_i, quad_mode_i, busy_i, hw_reset_n_i, cs_n, sclk, drv;
  wire  [3:0]   io_o, oe_n, hio, wio;
  wire          pd, rdy, srst;
  logic [127:0] r;
  logic [31:0]  s;
  logic [7:0]   ops [3] = '{`FIDP_OP_MFR_DEV_DUAL, `FIDP_OP_MFR_DEV_QUAD, `FIDP_OP_UNIQUE_ID};
  int           error_cnt, samples_checked, n;
  assign wio = (~oe_n & io_o) | (oe_n & hio);
  fidp_flash_id #(.MFR_ID(M), .DEV_ID(D), .MEM_TYPE(T), .CAPACITY(C), .UNIQUE_ID(U),
    .PD_CYC(10), .REL_CYC(10), .REL_ID_CYC(10)) fidp_flash_id_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(wio), .io_o(io_o),
    .io_oe_n_o(oe_n), .quad_mode_i(quad_mode_i), .busy_i(busy_i),
    .hw_reset_n_i(hw_reset_n_i), .powered_down_o(pd), .ready_o(rdy), .soft_reset_o(srst));
  fidp_host fidp_host_inst (.clk_i(clk_i), .io_i(wio), .cs_n_o(cs_n), .sclk_o(sclk),
    .io_o(hio));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (oe_n != 4'hF) drv <= 1'b1;
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The host must keep select high until the timers finish, so every frame waits here.
  task automatic fr(input logic [7:0] op, input int ol, input logic [127:0] pre,
                    input int np, input int pl, input int nr, input int rl);
    drv = 1'b0;
    fidp_host_inst.frame(op, ol, pre, np, pl, nr, rl, r);
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 100) chk("ready wait", 1, 0);
  endtask
  task automatic pdn;
    fr(`FIDP_OP_PWR_DOWN, 1, 0, 0, 1, 0, 1);
  endtask
  initial begin
    #300000;
    error_cnt++;
    close_out();
  end
  initial begin
    rst_i = 1'b1;
    quad_mode_i = 1'b0;
    busy_i = 1'b0;
    hw_reset_n_i = 1'b1;
    drv = 1'b0;
    s = 32'hEAE1172E;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("pd after reset", 0, pd);
    chk("ready after reset", 1, rdy);
    fr(`FIDP_OP_IDENTITY, 1, 0, 0, 1, 48, 1);
    chk("identity", {M, T, C, M, T, C}, r);
    for (int a = 0; a < 2; a++) begin
      s = nx(s);
      fr(`FIDP_OP_MFR_DEV_ID, 1, {24'(a), 104'h0}, 24, 1, 32, 1);
      chk("mfr dev single", a ? {D, M, D, M} : {M, D, M, D}, r);
      fr(`FIDP_OP_MFR_DEV_DUAL, 1, {24'(a), s[7:0], 96'h0}, 32, 2, 32, 2);
      chk("mfr dev dual", a ? {D, M, D, M} : {M, D, M, D}, r);
      fr(`FIDP_OP_MFR_DEV_QUAD, 1, {24'(a), s[23:0], 80'h0}, 48, 4, 32, 4);
      chk("mfr dev quad", a ? {D, M, D, M} : {M, D, M, D}, r);
    end
    repeat (2) begin
      s = nx(s);
      fr(`FIDP_OP_UNIQUE_ID, 1, {s, 96'h0}, 32, 1, 128, 1);
      chk("unique", U, r);
    end
    fr(`FIDP_OP_RELEASE_ID, 1, 0, 24, 1, 16, 1);
    chk("device id", {D, D}, r);
    $display("test serial reads done");
    quad_mode_i = 1'b1;
    fr(`FIDP_OP_IDENTITY, 4, 0, 0, 4, 24, 4);
    chk("quad identity", {M, T, C}, r);
    fr(`FIDP_OP_MFR_DEV_ID, 4, {24'h000001, 104'h0}, 24, 4, 16, 4);
    chk("quad mfr dev", {D, M}, r);
    fr(`FIDP_OP_RELEASE_ID, 4, 0, 24, 4, 8, 4);
    chk("quad dev id", D, r);
    foreach (ops[i]) begin
      fr(ops[i], 4, 0, 32, 4, 16, 4);
      chk("quad refused", 0, drv);
    end
    fr(`FIDP_OP_PWR_DOWN, 4, 0, 0, 4, 0, 4);
    chk("quad pd", 1, pd);
    fr(`FIDP_OP_RELEASE_ID, 4, 0, 0, 4, 0, 4);
    chk("quad wake", 0, pd);
    quad_mode_i = 1'b0;
    $display("test quad mode done");
    pdn();
    chk("pd entry", 1, pd);
    fr(`FIDP_OP_IDENTITY, 1, 0, 0, 1, 24, 1);
    chk("pd ignores id", 0, drv);
    fr(8'h05, 1, 0, 0, 1, 16, 1);
    chk("pd ignores status", 0, drv);
    busy_i = 1'b1;
    fr(`FIDP_OP_RELEASE_ID, 1, 0, 0, 1, 0, 1);
    chk("busy keeps pd", 1, pd);
    busy_i = 1'b0;
    fr(`FIDP_OP_RELEASE_ID, 1, 0, 0, 1, 0, 1);
    chk("release", 0, pd);
    fr(`FIDP_OP_PWR_DOWN, 1, 0, 1, 1, 0, 1);
    chk("pd after nine bits", 0, pd);
    pdn();
    fr(`FIDP_OP_RELEASE_ID, 1, 0, 24, 1, 8, 1);
    chk("wake id", D, r);
    chk("wake with id", 0, pd);
    $display("test power down done");
    pdn();
    fr(`FIDP_OP_RESET_EN, 1, 0, 0, 1, 0, 1);
    fr(`FIDP_OP_RESET, 1, 0, 0, 1, 0, 1);
    chk("soft reset wakes", 0, pd);
    pdn();
    hw_reset_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    hw_reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("hw reset wakes", 0, pd);
    pdn();
    chk("pd after hw reset", 1, pd);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("pd after second reset", 0, pd);
    $display("test resets done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
